// ==== include/mode_control_defines.vh ====
// constants for the operating-mode sequencer of the dual-string led driver
// assumes: included by bare name from the design files under hw/
`ifndef MODE_CONTROL_DEFINES_VH
`define MODE_CONTROL_DEFINES_VH

// ***********************************
// frame field positions
// ***********************************
`define FRAME_DATA_W       24
`define KEY_BIT            1
`define DRIVE_EN_BIT       2
`define SLEEP_REQ_BIT      3
`define CTRL_SEL_W         2
`define CTRL_SEL_FIRST     2'h1
`define CTRL_SEL_SECOND    2'h2

// ***********************************
// timing
// ***********************************
`define CLK_PERIOD_NS      40
`define RESET_DELAY_NS     400
`define SLEEP_ENTRY_NS_DEF 1000000
`define WAKE_DETECT_NS_DEF 50000
`define AUTO_RESTART_NS_DEF 10000000
`define TIMER_W            32

// ***********************************
// pin synchroniser layout
// ***********************************
`define SYNC_W             4
`define SYNC_CSN           0
`define SYNC_DIN           1
`define SYNC_SPI_UV        2
`define SYNC_WD_FAIL       3
`define SYNC_RST           4'h1

`endif

// ==== hw/pin_sync.v ====
// two-stage synchroniser for the asynchronous mode-control pins
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/10ps
`include "mode_control_defines.vh"

module pin_sync #(
   parameter             WIDTH   = `SYNC_W,
   parameter [WIDTH-1:0] RST_VAL = `SYNC_RST
) (
   input  wire             REF_CLK,
   input  wire             NRST,
   input  wire [WIDTH-1:0] PIN_IN,
   output wire [WIDTH-1:0] PIN_SYNC
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   // first stage feeds only the second one
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         stage1_reg <= RST_VAL;
         stage2_reg <= RST_VAL;
      end else begin
         stage1_reg <= PIN_IN;
         stage2_reg <= stage1_reg;
      end
   end

   assign PIN_SYNC = stage2_reg;

endmodule

// ==== hw/led_mode_control.v ====
// operating-mode sequencer: standby, pre-standby, reset, limp home, active
// assumes: frames arrive decoded from the serial port logic on REF_CLK,
// CSN, DIN, SPI_UV and WD_FAIL are asynchronous pins
`timescale 1ns/10ps
`include "mode_control_defines.vh"

module led_mode_control #(
   parameter SLEEP_ENTRY_NS  = `SLEEP_ENTRY_NS_DEF,
   parameter WAKE_DETECT_NS  = `WAKE_DETECT_NS_DEF,
   parameter AUTO_RESTART_NS = `AUTO_RESTART_NS_DEF
) (
   input  wire                      REF_CLK,
   input  wire                      NRST,
   input  wire                      CSN,
   input  wire                      DIN,
   input  wire                      SPI_UV,
   input  wire                      WD_FAIL,
   input  wire                      FRAME_STROBE,
   input  wire                      FRAME_WRITE,
   input  wire [`CTRL_SEL_W-1:0]    FRAME_REG_SEL,
   input  wire [`FRAME_DATA_W-1:0]  FRAME_DATA,
   input  wire                      FUNC_ERR_SET,
   output wire [4:0]                MODE,
   output wire                      BOOST_EN,
   output wire                      BUCK1_EN,
   output wire                      BUCK2_EN,
   output wire                      SPI_ACTIVE,
   output wire                      REGS_DEFAULT,
   output wire                      FUNC_ERR_FLAG,
   output wire                      KEY_PENDING
);

   // ***********************************
   // states and derived counts
   // ***********************************
   localparam [4:0] ST_STANDBY = 5'h01;
   localparam [4:0] ST_PRESTBY = 5'h02;
   localparam [4:0] ST_RESET   = 5'h04;
   localparam [4:0] ST_LIMP    = 5'h08;
   localparam [4:0] ST_ACTIVE  = 5'h10;

   // least time rounds up, never below one cycle
   function [`TIMER_W-1:0] ns_to_cycles;
      input integer ns;
      integer       cyc;
      begin
         cyc = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
         if (cyc < 1) begin
            cyc = 1;
         end
         ns_to_cycles = cyc[`TIMER_W-1:0];
      end
   endfunction

   localparam [`TIMER_W-1:0] RESET_CYC   = ns_to_cycles(`RESET_DELAY_NS);
   localparam [`TIMER_W-1:0] SLEEP_CYC   = ns_to_cycles(SLEEP_ENTRY_NS);
   localparam [`TIMER_W-1:0] WAKE_CYC    = ns_to_cycles(WAKE_DETECT_NS);
   localparam [`TIMER_W-1:0] RESTART_CYC = ns_to_cycles(AUTO_RESTART_NS);
   localparam [`TIMER_W-1:0] TIMER_ZERO  = {`TIMER_W{1'b0}};
   localparam [`TIMER_W-1:0] TIMER_ONE   = {{(`TIMER_W-1){1'b0}}, 1'b1};

   // ***********************************
   // pin synchronisers
   // ***********************************
   wire [`SYNC_W-1:0] pins_sync;

   pin_sync #(
      .WIDTH   (`SYNC_W),
      .RST_VAL (`SYNC_RST)
   ) u_pin_sync (
      .REF_CLK  (REF_CLK),
      .NRST     (NRST),
      .PIN_IN   ({WD_FAIL, SPI_UV, DIN, CSN}),
      .PIN_SYNC (pins_sync)
   );

   wire csn_s     = pins_sync[`SYNC_CSN];
   wire din_s     = pins_sync[`SYNC_DIN];
   wire spi_uv_s  = pins_sync[`SYNC_SPI_UV];
   wire wd_fail_s = pins_sync[`SYNC_WD_FAIL];

   // ***********************************
   // state registers
   // ***********************************
   reg [4:0]          state_reg;
   reg [4:0]          state_next;
   reg [`TIMER_W-1:0] timer_reg;
   reg [`TIMER_W-1:0] timer_next;
   reg                key_reg;
   reg                key_next;
   reg                ferr_reg;
   reg                ferr_next;
   reg                boost_reg;
   reg                buck1_reg;
   reg                buck2_reg;
   reg                spi_on_reg;
   reg                dflt_reg;

   // ***********************************
   // frame decoding
   // ***********************************
   wire port_live  = (state_reg == ST_PRESTBY) | (state_reg == ST_LIMP) |
                     (state_reg == ST_ACTIVE);
   wire frame_in   = FRAME_STROBE & port_live;
   wire wr_first   = frame_in & FRAME_WRITE & (FRAME_REG_SEL == `CTRL_SEL_FIRST);
   wire wr_second  = frame_in & FRAME_WRITE & (FRAME_REG_SEL == `CTRL_SEL_SECOND);
   wire key_frame  = wr_first & FRAME_DATA[`KEY_BIT];
   wire drive_en   = FRAME_DATA[`DRIVE_EN_BIT];
   wire sleep_req  = FRAME_DATA[`SLEEP_REQ_BIT];
   wire keyed_cmd  = wr_second & key_reg;
   wire cmd_sleep  = keyed_cmd & ~drive_en & sleep_req;
   wire cmd_wake   = keyed_cmd & drive_en & ~sleep_req;
   wire cmd_relock = keyed_cmd & drive_en & sleep_req;
   wire cmd_drop   = wr_second & ~drive_en & ~sleep_req;

   wire sleep_cond = csn_s & ~din_s;
   wire wake_cond  = din_s | ~csn_s;

   // key holds for exactly one following frame
   always @* begin
      key_next = key_reg;
      if (!port_live) begin
         key_next = 1'b0;
      end else if (FRAME_STROBE) begin
         key_next = key_frame;
      end
   end

   // ***********************************
   // mode sequencing
   // ***********************************
   always @* begin
      state_next = state_reg;
      timer_next = timer_reg + TIMER_ONE;
      case (state_reg)
         ST_STANDBY: begin
            if (!wake_cond) begin
               timer_next = TIMER_ZERO;
            end else if (timer_reg == WAKE_CYC) begin
               state_next = ST_RESET;
            end
         end
         ST_PRESTBY: begin
            if (!sleep_cond) begin
               timer_next = TIMER_ZERO;
            end else if (timer_reg == SLEEP_CYC) begin
               state_next = ST_STANDBY;
            end
         end
         ST_RESET: begin
            if (timer_reg == RESET_CYC - TIMER_ONE) begin
               state_next = ST_LIMP;
            end
         end
         ST_LIMP: begin
            // other writes land here with no effect on the converters
            if (cmd_sleep) begin
               state_next = ST_STANDBY;
            end else if (cmd_wake) begin
               state_next = ST_ACTIVE;
            end
            if (timer_reg == RESTART_CYC - TIMER_ONE) begin
               timer_next = TIMER_ZERO;
            end
         end
         ST_ACTIVE: begin
            if (spi_uv_s | wd_fail_s) begin
               state_next = ST_RESET;
            end else if (cmd_drop | cmd_relock) begin
               state_next = ST_RESET;
            end else if (cmd_sleep) begin
               state_next = ST_PRESTBY;
            end
         end
         default: begin
            state_next = ST_STANDBY;
         end
      endcase
      if (state_next != state_reg) begin
         timer_next = TIMER_ZERO;
      end
   end

   // ***********************************
   // functional error flag
   // ***********************************
   wire restart_tick = (state_reg == ST_LIMP) & (timer_reg == RESTART_CYC - TIMER_ONE);

   // a new error wins over the auto-restart clear, but the reset-mode clear wins over a new error
   always @* begin
      ferr_next = ferr_reg;
      if (state_reg == ST_RESET) begin
         ferr_next = 1'b0;
      end else if (FUNC_ERR_SET) begin
         ferr_next = 1'b1;
      end else if (restart_tick) begin
         ferr_next = 1'b0;
      end
   end

   // ***********************************
   // registers
   // ***********************************
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         state_reg  <= ST_STANDBY;
         timer_reg  <= TIMER_ZERO;
         key_reg    <= 1'b0;
         ferr_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         timer_reg  <= timer_next;
         key_reg    <= key_next;
         ferr_reg   <= ferr_next;
      end
   end

   // ***********************************
   // converter and port gating
   // ***********************************
   // outputs follow the next state so they change with the mode
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         boost_reg  <= 1'b0;
         buck1_reg  <= 1'b0;
         buck2_reg  <= 1'b0;
         spi_on_reg <= 1'b0;
         dflt_reg   <= 1'b0;
      end else begin
         case (state_next)
            ST_PRESTBY: begin
               boost_reg  <= 1'b0;
               buck1_reg  <= 1'b0;
               buck2_reg  <= 1'b0;
               spi_on_reg <= 1'b1;
               dflt_reg   <= 1'b0;
            end
            ST_RESET: begin
               boost_reg  <= 1'b0;
               buck1_reg  <= 1'b0;
               buck2_reg  <= 1'b0;
               spi_on_reg <= 1'b0;
               dflt_reg   <= 1'b1;
            end
            ST_LIMP: begin
               boost_reg  <= 1'b1;
               buck1_reg  <= din_s;
               buck2_reg  <= 1'b0;
               spi_on_reg <= 1'b1;
               dflt_reg   <= 1'b0;
            end
            ST_ACTIVE: begin
               boost_reg  <= 1'b1;
               buck1_reg  <= 1'b1;
               buck2_reg  <= 1'b1;
               spi_on_reg <= 1'b1;
               dflt_reg   <= 1'b0;
            end
            default: begin
               boost_reg  <= 1'b0;
               buck1_reg  <= 1'b0;
               buck2_reg  <= 1'b0;
               spi_on_reg <= 1'b0;
               dflt_reg   <= 1'b0;
            end
         endcase
      end
   end

   assign MODE          = state_reg;
   assign BOOST_EN      = boost_reg;
   assign BUCK1_EN      = buck1_reg;
   assign BUCK2_EN      = buck2_reg;
   assign SPI_ACTIVE    = spi_on_reg;
   assign REGS_DEFAULT  = dflt_reg;
   assign FUNC_ERR_FLAG = ferr_reg;
   assign KEY_PENDING   = key_reg;

endmodule

// ==== test/mode_checker.sv ====
// port assertions for the mode sequencer
// assumes: bound onto led_mode_control, one clock domain
`timescale 1ns/10ps
module mode_checker (
   input wire        REF_CLK,
   input wire        NRST,
   input wire        CSN,
   input wire        DIN,
   input wire        SPI_UV,
   input wire        WD_FAIL,
   input wire        FRAME_STROBE,
   input wire        FRAME_WRITE,
   input wire [1:0]  FRAME_REG_SEL,
   input wire [23:0] FRAME_DATA,
   input wire        FUNC_ERR_SET,
   input wire [4:0]  MODE,
   input wire        BOOST_EN,
   input wire        BUCK1_EN,
   input wire        BUCK2_EN,
   input wire        SPI_ACTIVE,
   input wire        REGS_DEFAULT,
   input wire        FUNC_ERR_FLAG,
   input wire        KEY_PENDING
);
   // ***********************************
   // properties
   // ***********************************
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   wire kf = FRAME_STROBE && FRAME_WRITE && FRAME_REG_SEL == 2'h1 && FRAME_DATA[1];
   wire f2 = FRAME_STROBE && FRAME_WRITE && FRAME_REG_SEL == 2'h2;
   wire [1:0] ds = FRAME_DATA[3:2];
   property p_rlen; $rose(MODE[2]) |-> MODE[2] [*8] ##1 MODE[2] ##1 MODE[2] ##1 MODE[3]; endproperty
   a_rlen: assert property (p_rlen) else $error("reset mode length");
   property p_rout; REGS_DEFAULT == MODE[2] && !(MODE[2] && SPI_ACTIVE); endproperty
   a_rout: assert property (p_rout) else $error("reset mode outputs");
   property p_pre; MODE == 5'h02 |-> !BOOST_EN && !BUCK1_EN && !BUCK2_EN && SPI_ACTIVE; endproperty
   a_pre: assert property (p_pre) else $error("pre-standby gating");
   property p_act; MODE == 5'h10 |-> BOOST_EN && BUCK1_EN && BUCK2_EN && SPI_ACTIVE; endproperty
   a_act: assert property (p_act) else $error("active gating");
   property p_limp; MODE == 5'h08 |-> BOOST_EN && !BUCK2_EN && SPI_ACTIVE
      && BUCK1_EN == $past(DIN, 3); endproperty
   a_limp: assert property (p_limp) else $error("limp gating");
   property p_flt; MODE == 5'h10 && (SPI_UV || WD_FAIL) |-> ##[1:4] MODE == 5'h04; endproperty
   a_flt: assert property (p_flt) else $error("fault exit");
   property p_one; MODE == 5'h10 && f2 && ds == 2'h0 |=> MODE == 5'h04; endproperty
   a_one: assert property (p_one) else $error("single frame exit");
   property p_aseq; MODE == 5'h10 && KEY_PENDING && f2 && ds[1]
      |=> MODE == ($past(FRAME_DATA[2]) ? 5'h04 : 5'h02); endproperty
   a_aseq: assert property (p_aseq) else $error("active sequence");
   property p_lseq; MODE == 5'h08 && KEY_PENDING && f2 && ds[1] != ds[0]
      |=> MODE == ($past(FRAME_DATA[3]) ? 5'h01 : 5'h10); endproperty
   a_lseq: assert property (p_lseq) else $error("limp sequence");
   property p_key; MODE == 5'h08 && FRAME_STROBE |=> KEY_PENDING == $past(kf); endproperty
   a_key: assert property (p_key) else $error("key arming");
   property p_wake; $fell(MODE[0]) |-> MODE == 5'h04; endproperty
   a_wake: assert property (p_wake) else $error("standby exit");
   c_act: cover property (MODE == 5'h10);
   c_slp: cover property (MODE == 5'h02 ##1 MODE == 5'h01);
   c_clr: cover property (MODE[3] && $fell(FUNC_ERR_FLAG));
endmodule
bind led_mode_control mode_checker chk (.REF_CLK(REF_CLK), .NRST(NRST), .CSN(CSN),
   .DIN(DIN), .SPI_UV(SPI_UV), .WD_FAIL(WD_FAIL), .FRAME_STROBE(FRAME_STROBE),
   .FRAME_WRITE(FRAME_WRITE), .FRAME_REG_SEL(FRAME_REG_SEL), .FRAME_DATA(FRAME_DATA),
   .FUNC_ERR_SET(FUNC_ERR_SET), .MODE(MODE), .BOOST_EN(BOOST_EN), .BUCK1_EN(BUCK1_EN),
   .BUCK2_EN(BUCK2_EN), .SPI_ACTIVE(SPI_ACTIVE), .REGS_DEFAULT(REGS_DEFAULT),
   .FUNC_ERR_FLAG(FUNC_ERR_FLAG), .KEY_PENDING(KEY_PENDING));

// ==== test/host_model.sv ====
// host side: frame strobes plus chip select, dimming and fault pins
// assumes: frames already decoded on REF_CLK
`timescale 1ns/10ps
module host_model (
   input  wire        REF_CLK,
   output reg         CSN,
   output reg         DIN,
   output reg         SPI_UV,
   output reg         WD_FAIL,
   output reg         FRAME_STROBE,
   output reg         FRAME_WRITE,
   output reg  [1:0]  FRAME_REG_SEL,
   output reg  [23:0] FRAME_DATA
);
   initial begin
      CSN = 1'b1;
      DIN = 1'b0;
      SPI_UV = 1'b0;
      WD_FAIL = 1'b0;
      FRAME_STROBE = 1'b0;
      FRAME_WRITE = 1'b0;
      FRAME_REG_SEL = 2'h0;
      FRAME_DATA = 24'h0;
   end
   // consecutive calls give back-to-back strobes
   task frame(input w, input [1:0] s, input [23:0] d);
      begin
         @(posedge REF_CLK);
         CSN <= 1'b0;
         FRAME_STROBE <= 1'b1;
         FRAME_WRITE <= w;
         FRAME_REG_SEL <= s;
         FRAME_DATA <= d;
      end
   endtask
   // released data inverted so a stale word never looks valid
   task idle;
      begin
         @(posedge REF_CLK);
         CSN <= 1'b1;
         FRAME_STROBE <= 1'b0;
         FRAME_DATA <= ~FRAME_DATA;
      end
   endtask
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the mode sequencer
// assumes: short timing parameters, host_model drives frames and pins
`timescale 1ns/10ps
module tb_top;
   localparam SLEEP_CYC = 10;
   localparam WAKE_CYC  = 5;
   localparam RST_CYC   = 10;
   localparam RS_CYC    = 50;
   reg        ref_clk, nrst, func_err_set;
   wire       csn, din, spi_uv, wd_fail, fs, fw;
   wire [1:0] sel;
   wire [23:0] fd;
   wire [4:0] mode;
   wire       boost, buck1, buck2, spi_act, regs_def, ferr, key;
   integer    n_mismatch, checked, cyc, n, i;
   host_model h (.REF_CLK(ref_clk), .CSN(csn), .DIN(din), .SPI_UV(spi_uv),
      .WD_FAIL(wd_fail), .FRAME_STROBE(fs), .FRAME_WRITE(fw), .FRAME_REG_SEL(sel),
      .FRAME_DATA(fd));
   led_mode_control #(.SLEEP_ENTRY_NS(400), .WAKE_DETECT_NS(200), .AUTO_RESTART_NS(2000))
   dut (.REF_CLK(ref_clk), .NRST(nrst), .CSN(csn), .DIN(din), .SPI_UV(spi_uv),
      .WD_FAIL(wd_fail), .FRAME_STROBE(fs), .FRAME_WRITE(fw), .FRAME_REG_SEL(sel),
      .FRAME_DATA(fd), .FUNC_ERR_SET(func_err_set), .MODE(mode), .BOOST_EN(boost),
      .BUCK1_EN(buck1), .BUCK2_EN(buck2), .SPI_ACTIVE(spi_act), .REGS_DEFAULT(regs_def),
      .FUNC_ERR_FLAG(ferr), .KEY_PENDING(key));
   task chk(input string nm, input [23:0] seen, input [23:0] exp);
      begin
         checked++;
         if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // outputs read at the falling edge, well clear of updates
   task wait_mode(input [4:0] m, input integer lim);
      begin
         n = 0;
         @(negedge ref_clk);
         while (mode !== m && n < lim) begin
            @(negedge ref_clk);
            n++;
         end
         chk("mode", mode, m);
      end
   endtask
   task seq(input [23:0] d);
      begin
         h.frame(1'b1, 2'h1, 24'h2);
         h.frame(1'b1, 2'h2, d);
         h.idle;
      end
   endtask
   task go_active;
      begin
         seq(24'h4);
         wait_mode(5'h10, 3);
      end
   endtask
   task t_wake;
      begin
         @(posedge ref_clk) h.DIN <= 1'b1;
         repeat (3) @(posedge ref_clk);
         h.DIN <= 1'b0;
         wait_mode(5'h01, 8);
         // pulse plus both sync stages stays shorter than the wake time
         repeat (8) @(negedge ref_clk);
         chk("short", mode, 5'h01);
         @(posedge ref_clk) h.DIN <= 1'b1;
         wait_mode(5'h04, 20);
         chk("wake", n >= WAKE_CYC, 1);
         chk("regdef", {regs_def, spi_act}, 2'h2);
         wait_mode(5'h08, 12);
         // first look falls one cycle into reset mode
         chk("rstlen", n + 1, RST_CYC);
      end
   endtask
   task t_limp;
      begin
         chk("limp", {boost, buck1, buck2}, 3'h6);
         h.frame(1'b1, 2'h2, 24'h0);
         h.frame(1'b0, 2'h1, 24'h2);
         h.idle;
         wait_mode(5'h08, 0);
         chk("key", key, 1'b0);
         @(posedge ref_clk) h.DIN <= 1'b0;
         repeat (4) @(negedge ref_clk);
         chk("buck1", buck1, 1'b0);
         @(posedge ref_clk) func_err_set <= 1'b1;
         @(posedge ref_clk) func_err_set <= 1'b0;
         @(negedge ref_clk);
         chk("ferr", ferr, 1'b1);
         n = 0;
         while (ferr === 1'b1 && n < RS_CYC + 5) begin
            @(negedge ref_clk);
            n++;
         end
         chk("autoclr", {ferr, n <= RS_CYC}, 2'h1);
      end
   endtask
   task t_exits;
      begin
         h.frame(1'b1, 2'h1, 24'h2);
         h.frame(1'b0, 2'h2, 24'h4);
         @(negedge ref_clk);
         chk("arm", key, 1'b1);
         h.frame(1'b1, 2'h2, 24'h4);
         h.idle;
         wait_mode(5'h08, 0);
         go_active;
         h.frame(1'b1, 2'h2, 24'h0);
         h.idle;
         wait_mode(5'h04, 1);
         wait_mode(5'h08, 12);
         go_active;
         seq(24'hc);
         wait_mode(5'h04, 1);
         wait_mode(5'h08, 12);
         for (i = 0; i < 2; i++) begin
            go_active;
            @(posedge ref_clk);
            if (i == 0) h.SPI_UV <= 1'b1;
            else h.WD_FAIL <= 1'b1;
            wait_mode(5'h04, 5);
            @(posedge ref_clk) h.SPI_UV <= 1'b0;
            h.WD_FAIL <= 1'b0;
            wait_mode(5'h08, 12);
         end
      end
   endtask
   task t_sleep;
      begin
         go_active;
         seq(24'h8);
         wait_mode(5'h02, 1);
         chk("pre", {boost, buck1, buck2, spi_act}, 4'h1);
         repeat (6) @(posedge ref_clk);
         h.DIN <= 1'b1;
         @(posedge ref_clk) h.DIN <= 1'b0;
         wait_mode(5'h01, 30);
         chk("restart", n > SLEEP_CYC, 1);
         @(posedge ref_clk) h.DIN <= 1'b1;
         wait_mode(5'h04, 20);
         wait_mode(5'h08, 12);
         seq(24'h8);
         wait_mode(5'h01, 1);
      end
   endtask
   task close_out;
      begin
         $display("mismatches %0d of %0d checks", n_mismatch, checked);
         if (n_mismatch == 0 && checked > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // hang guard, run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out;
      end
   end
   initial begin
      n_mismatch = 0;
      checked = 0;
      cyc = 0;
      nrst = 1'b0;
      func_err_set = 1'b0;
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      t_wake;
      t_limp;
      t_exits;
      t_sleep;
      close_out;
   end
endmodule
